// >>> hw/spm_consts.svh
/*
 * Constants of the SPI mode-fault and flag control block: widths,
 * reset values and serial-clock half-period counts.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH

// Bits per transferred byte and half-periods per byte
`define SPM_BYTE_BITS 8
`define SPM_HALVES 16
// Master half-period in bus cycles for the four rate selections
`define SPM_HALF_DIV2 6'h01
`define SPM_HALF_DIV8 6'h04
`define SPM_HALF_DIV32 6'h10
`define SPM_HALF_DIV128 6'h40
// Reset values of the control words (master select and phase set)
`define SPM_CTRL_RST 6'h14
`define SPM_SCTRL_RST 4'h0
`define SPM_DATA_RST 8'h00

`endif

// >>> hw/spm_pkg.sv
/*
 * Types shared by the SPI control block and its bench.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package spm_pkg;

   // Control word as software writes it
   typedef struct packed {
      logic rx_irq_enable;
      logic master_select;
      logic cpol;
      logic clock_phase;
      logic module_enable;
      logic transmit_irq_enable;
   } spm_ctrl_t;

   // Status-control word: enables and rate selection
   typedef struct packed {
      logic mode_fault_enable;
      logic error_irq_enable;
      logic rate_select_hi;
      logic rate_select_lo;
   } spm_sctrl_t;

   // Flags shown to software
   typedef struct packed {
      logic receive_full_flag;
      logic overrun_flag;
      logic mode_fault_flag;
      logic transmit_empty_flag;
   } spm_flags_t;

   // Pin drive of the three serial lines
   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic mosi_o;
      logic mosi_oe;
      logic miso_o;
      logic miso_oe;
   } spm_pins_t;

   typedef enum logic [1:0] {
      SPM_IDLE = 2'b01,
      SPM_SHIFT = 2'b10
   } spm_state_t;

endpackage

// >>> hw/spm_port.sv
/*
 * Byte-wide SPI port control: mode-fault detection, flags, interrupt
 * levels, partial reset, stop and break behaviour, master engine.
 * Assumes register strobes arrive one cycle wide on mclk, and that
 * the slave-side serial clock comes from the external master.
 */
`timescale 1ns/1ns
`include "spm_consts.svh"

// Overview of operation
// - Master drives clock and MOSI, reads MISO; slave reverses directions.
// - Mode fault sets only while enabled; disabling keeps a set flag.
// - Enabled master flags mode fault whenever select input is low.
// - Master fault clears enable, sets tx empty, clears counter, frees pins.
// - Slave flags mode fault when select rises during a transfer.
// - Phase zero slave transfer spans select fall to end of eighth bit.
// - Phase one slave transfer starts at first clock edge while selected.
// - Phase zero select then deselect faults; phase one does not.
// - Slave fault only sets flag and request; enable and state kept.
// - Mode fault never changes the master select bit.
// - Deselected slave floats MISO and ignores serial clock edges.
// - Fault flag clears on status read then control write, no fault.
// - Transmit request needs tx empty, its enable and module enable.
// - Receive request follows receive full and its enable only.
// - One error enable gates overrun and mode fault onto shared request.
// - Receive full clears by status then data read; tx empty by write.
// - Receive full sets per received byte; tx empty per shifter load.
// - Disabled port sets tx empty, aborts, clears shifter, frees pins.
// - Control bits and receive, overrun, fault flags reset only by reset.
// - Port keeps running in wait mode; requests stay usable for wake.
// - Stop freezes master engine and shifter loads, state kept; reset aborts everything.
// - Protected break write leaves tx empty, shifter and transfer alone.
module spm_port
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ctrl_wr,
   input wire spm_pkg::spm_ctrl_t ctrl_wdata,
   input wire logic sctrl_wr,
   input wire spm_pkg::spm_sctrl_t sctrl_wdata,
   input wire logic status_rd,
   input wire logic data_rd,
   input wire logic data_wr,
   input wire logic [7:0] data_wdata,
   input wire logic stop_mode,
   input wire logic break_active,
   input wire logic break_clear_enable,
   input wire logic serial_clock_pin,
   input wire logic ss_n,
   input wire logic mosi_i,
   input wire logic miso_i,
   output spm_pkg::spm_ctrl_t ctrl,
   output spm_pkg::spm_sctrl_t sctrl,
   output spm_pkg::spm_flags_t flags,
   output logic [7:0] rx_data,
   output logic tx_irq,
   output logic rx_err_irq,
   output logic port_owned,
   output spm_pkg::spm_pins_t pins
);

   spm_pkg::spm_ctrl_t ctrl_r;
   spm_pkg::spm_sctrl_t sctrl_r;
   spm_pkg::spm_state_t state_r;
   logic rx_full_r, ovr_r, mode_fault_flag_r, tx_empty_r;
   logic rx_arm_r, ovr_arm_r, mode_fault_flag_arm_r;
   logic [7:0] txbuf_r, shift_r, rx_data_r;
   logic [5:0] div_r;
   logic [3:0] half_r;
   logic [1:0] ss_sync_r, miso_sync_r;
   logic ss_prev_r, xfer_r, sck_r;
   logic [2:0] done_sync_r, start_sync_r;
   logic is_master, is_slave, master_fault, slave_fault, fault_cond;
   logic clr_ok, wr_ok, half_end, byte_end, slave_done, slave_start;
   logic [5:0] half_len;
   // Link-domain state, clocked by the external serial clock
   logic lclk, lrst;
   logic [3:0] lcnt_r;
   logic [2:0] dcnt_r;
   logic [7:0] lshift_r, lrx_r;
   logic ldone_tgl_r, lstart_tgl_r;

   assign is_master = ctrl_r.module_enable & ctrl_r.master_select;
   assign is_slave = ctrl_r.module_enable & ~ctrl_r.master_select;
   // Select input sampled low while an enabled master
   assign master_fault = is_master & sctrl_r.mode_fault_enable & ~ss_sync_r[1];
   // Select rising while a slave transfer is open
   assign slave_fault = is_slave & sctrl_r.mode_fault_enable & xfer_r
      & ss_sync_r[1] & ~ss_prev_r;
   assign fault_cond = master_fault | slave_fault;
   // Flag clears are blocked during a protected break
   assign clr_ok = ~break_active | break_clear_enable;
   assign wr_ok = data_wr & clr_ok;
   assign slave_done = done_sync_r[2] ^ done_sync_r[1];
   assign slave_start = start_sync_r[2] ^ start_sync_r[1];

   // Half-period length from the rate selection
   always_comb
   begin
      case ({sctrl_r.rate_select_hi, sctrl_r.rate_select_lo})
         2'b00: half_len = `SPM_HALF_DIV2;
         2'b01: half_len = `SPM_HALF_DIV8;
         2'b10: half_len = `SPM_HALF_DIV32;
         default: half_len = `SPM_HALF_DIV128;
      endcase
   end

   // Stop freezes the divider; state is simply held
   assign half_end = (state_r == spm_pkg::SPM_SHIFT) & ~stop_mode
      & (div_r == half_len - 6'h01);
   assign byte_end = half_end & (half_r == 4'(`SPM_HALVES - 1));

   // Pin synchronisers; first stage read only by the second
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         ss_sync_r <= 2'b11;
         miso_sync_r <= 2'b00;
         ss_prev_r <= 1'b1;
      end
      else
      begin
         ss_sync_r <= {ss_sync_r[0], ss_n};
         miso_sync_r <= {miso_sync_r[0], miso_i};
         ss_prev_r <= ss_sync_r[1];
      end
   end

   // Control words: only system reset restores them
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         ctrl_r <= `SPM_CTRL_RST;
         sctrl_r <= `SPM_SCTRL_RST;
      end
      else
      begin
         if (ctrl_wr)
            ctrl_r <= ctrl_wdata;
         // Fault wins over a simultaneous write; master select untouched
         if (master_fault)
            ctrl_r.module_enable <= 1'b0;
         if (sctrl_wr)
            sctrl_r <= sctrl_wdata;
      end
   end

   // Mode fault flag with its two-step clear
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         mode_fault_flag_r <= 1'b0;
         mode_fault_flag_arm_r <= 1'b0;
      end
      else
      begin
         if (fault_cond)
         begin
            mode_fault_flag_r <= 1'b1;
            mode_fault_flag_arm_r <= 1'b0;
         end
         else if (ctrl_wr && mode_fault_flag_arm_r && clr_ok)
         begin
            mode_fault_flag_r <= 1'b0;
            mode_fault_flag_arm_r <= 1'b0;
         end
         else if (status_rd && mode_fault_flag_r)
            mode_fault_flag_arm_r <= 1'b1;
      end
   end

   // Transmit buffer and its empty flag; set wins over a write
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         tx_empty_r <= 1'b1;
         txbuf_r <= `SPM_DATA_RST;
      end
      else
      begin
         if (wr_ok)
         begin
            txbuf_r <= data_wdata;
            tx_empty_r <= 1'b0;
         end
         if (!ctrl_r.module_enable || master_fault)
            tx_empty_r <= 1'b1;
         else if ((state_r == spm_pkg::SPM_IDLE) && !tx_empty_r && !stop_mode
            && (is_master || !xfer_r))
            tx_empty_r <= 1'b1;
      end
   end

   // Master engine: idle until a byte is queued, sixteen half-periods
   always_ff @(posedge mclk)
   begin
      if (!rst_n || !ctrl_r.module_enable || master_fault)
      begin
         state_r <= spm_pkg::SPM_IDLE;
         div_r <= 6'h00;
         half_r <= 4'h0;
      end
      else
      begin
         case (state_r)
            spm_pkg::SPM_IDLE:
            begin
               div_r <= 6'h00;
               half_r <= 4'h0;
               if (is_master && !tx_empty_r && !stop_mode)
                  state_r <= spm_pkg::SPM_SHIFT;
            end
            spm_pkg::SPM_SHIFT:
            begin
               if (stop_mode)
                  div_r <= div_r;
               else if (half_end)
               begin
                  div_r <= 6'h00;
                  half_r <= half_r + 4'h1;
                  if (byte_end)
                     state_r <= spm_pkg::SPM_IDLE;
               end
               else
                  div_r <= div_r + 6'h01;
            end
            default: state_r <= spm_pkg::SPM_IDLE;
         endcase
      end
   end

   // Shifter: master shifts here; slave parks its next byte here
   always_ff @(posedge mclk)
   begin
      if (!rst_n || !ctrl_r.module_enable || master_fault)
         shift_r <= `SPM_DATA_RST;
      else if ((state_r == spm_pkg::SPM_IDLE) && !tx_empty_r && !stop_mode
         && (is_master || !xfer_r))
         shift_r <= txbuf_r;
      else if (half_end && !half_r[0])
         shift_r <= {shift_r[6:0], miso_sync_r[1]};
   end

   // Master serial clock: phase decides which half is active
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         sck_r <= 1'b0;
      else
         sck_r <= ctrl_r.cpol ^ ((state_r == spm_pkg::SPM_SHIFT)
            & (half_r[0] ^ ctrl_r.clock_phase));
   end

   // Slave transfer window seen from the bus clock
   always_ff @(posedge mclk)
   begin
      if (!rst_n || !is_slave)
         xfer_r <= 1'b0; // keeps enable
      else if (ss_sync_r[1])
         xfer_r <= 1'b0;
      else if (!ctrl_r.clock_phase && ss_prev_r)
         xfer_r <= 1'b1;
      else if (ctrl_r.clock_phase && slave_start)
         xfer_r <= 1'b1;
      else if (slave_done)
         xfer_r <= 1'b0;
   end

   // Event toggles from the link domain, synchronised then edged
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         done_sync_r <= 3'h0;
         start_sync_r <= 3'h0;
      end
      else
      begin
         done_sync_r <= {done_sync_r[1:0], ldone_tgl_r};
         start_sync_r <= {start_sync_r[1:0], lstart_tgl_r};
      end
   end

   // Receive buffer, receive full and overrun with their clears
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         rx_full_r <= 1'b0;
         ovr_r <= 1'b0;
         rx_arm_r <= 1'b0;
         ovr_arm_r <= 1'b0;
         rx_data_r <= `SPM_DATA_RST;
      end
      else
      begin
         if (status_rd && rx_full_r)
            rx_arm_r <= 1'b1;
         if (status_rd && ovr_r)
            ovr_arm_r <= 1'b1;
         if (data_rd && clr_ok)
         begin
            if (rx_arm_r)
            begin
               rx_full_r <= 1'b0;
               rx_arm_r <= 1'b0;
            end
            if (ovr_arm_r)
            begin
               ovr_r <= 1'b0;
               ovr_arm_r <= 1'b0;
            end
         end
         // A completed byte outranks an overrun clear in the same cycle
         if ((is_master && byte_end) || (is_slave && slave_done))
         begin
            if (rx_full_r || ovr_r)
               ovr_r <= 1'b1;
            else
            begin
               rx_full_r <= 1'b1;
               rx_data_r <= is_master ? shift_r : lrx_r;
            end
         end
      end
   end

   // Slave sampling clock: rising edge is the capture edge for any mode
   assign lclk = serial_clock_pin ^ ctrl_r.cpol ^ ctrl_r.clock_phase;
   // Deselect or disable clears the link counters and shifter at once
   assign lrst = ss_n | ~is_slave;

   // Link capture: shift in, count bits, toggle on each full byte
   always_ff @(posedge lclk or posedge lrst)
   begin
      if (lrst)
      begin
         lcnt_r <= 4'h0;
         lshift_r <= 8'h00;
      end
      else
      begin
         lshift_r <= {lshift_r[6:0], mosi_i};
         lcnt_r <= (lcnt_r == 4'(`SPM_BYTE_BITS - 1)) ? 4'h0 : lcnt_r + 4'h1;
      end
   end

   // Completed byte and its toggle; kept through deselect for the bus side
   always_ff @(posedge lclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lrx_r <= 8'h00;
         ldone_tgl_r <= 1'b0;
      end
      else if (!lrst && (lcnt_r == 4'(`SPM_BYTE_BITS - 1)))
      begin
         lrx_r <= {lshift_r[6:0], mosi_i};
         ldone_tgl_r <= ~ldone_tgl_r;
      end
   end

   // Launch edge: bit index of MISO follows the captured count
   always_ff @(negedge lclk or posedge lrst)
   begin
      if (lrst)
         dcnt_r <= 3'h0;
      else
         dcnt_r <= lcnt_r[2:0];
   end

   // Phase one start marker on the first leading edge of a byte
   always_ff @(negedge lclk or negedge rst_n)
   begin
      if (!rst_n)
         lstart_tgl_r <= 1'b0;
      else if (!lrst && ctrl_r.clock_phase && (lcnt_r == 4'h0))
         lstart_tgl_r <= ~lstart_tgl_r;
   end

   // Interrupt levels follow flags and enables directly
   assign tx_irq = tx_empty_r & ctrl_r.transmit_irq_enable & ctrl_r.module_enable;
   assign rx_err_irq = (rx_full_r & ctrl_r.rx_irq_enable)
      | (sctrl_r.error_irq_enable & (ovr_r | mode_fault_flag_r));

   // Pin ownership and direction; slave MISO only while selected
   assign port_owned = ctrl_r.module_enable;
   assign pins.sck_o = sck_r;
   assign pins.sck_oe = is_master;
   assign pins.mosi_o = shift_r[7];
   assign pins.mosi_oe = is_master;
   assign pins.miso_o = shift_r[3'h7 - dcnt_r];
   assign pins.miso_oe = is_slave & ~ss_sync_r[1];

   assign ctrl = ctrl_r;
   assign sctrl = sctrl_r;
   assign flags = '{receive_full_flag: rx_full_r, overrun_flag: ovr_r,
      mode_fault_flag: mode_fault_flag_r, transmit_empty_flag: tx_empty_r};
   assign rx_data = rx_data_r;

endmodule

// >>> test/spm_far_end.sv
/*
 * Far side of the SPI port: an external master for slave tests and
 * an external slave that answers the complement of MOSI.
 * Assumes the bench calls its tasks hierarchically; serial clock 12 ns.
 */
`timescale 1ns/1ns
module spm_far_end
(
   output logic sclk,
   output logic ss_n,
   output logic mosi,
   output logic miso,
   input wire logic sck_o,
   input wire logic mosi_o
);
   // Link clock stands still at idle between frames
   initial
   begin
      sclk = 1'b0;
      ss_n = 1'b1;
      mosi = 1'b0;
   end

   // External slave echoes the inverse so a wrong sample shows up
   assign miso = ~mosi_o;

   // One phase-one byte, msb first, select held across all eight clocks
   task frame(input logic [7:0] b);
      int i;
      ss_n = 1'b0;
      #23;
      for (i = 7; i >= 0; i--)
      begin
         #6 sclk = 1'b1;
         // Launch on the leading edge, well clear of the capture edge
         mosi = b[i];
         #6 sclk = 1'b0;
      end
      #20 mosi = ~mosi; // Released line no longer shows last bit
      ss_n = 1'b1;
      #40;
   endtask

   // Select then deselect with no clock at all
   task select_pulse();
      ss_n = 1'b0;
      #63 ss_n = 1'b1;
      #40;
   endtask
endmodule

// >>> test/spm_port_monitor.sv
/*
 * Checker for the SPI port: flag, request and pin relations.
 * Assumes binding into spm_port; sees only its ports.
 */
`timescale 1ns/1ns
module spm_port_monitor
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ctrl_wr,
   input wire logic data_wr,
   input wire logic break_active,
   input wire logic break_clear_enable,
   input wire logic ss_n,
   input wire spm_pkg::spm_ctrl_t ctrl,
   input wire spm_pkg::spm_sctrl_t sctrl,
   input wire spm_pkg::spm_flags_t flags,
   input wire logic tx_irq,
   input wire logic rx_err_irq,
   input wire logic port_owned,
   input wire spm_pkg::spm_pins_t pins
);
   // All checks live on the bus clock
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // Request levels tied to their flags and enables
   tx_req_a: assert property (tx_irq == (flags.transmit_empty_flag & ctrl.transmit_irq_enable
      & ctrl.module_enable)) else $error("tx request wrong");
   err_req_a: assert property (rx_err_irq == ((flags.receive_full_flag & ctrl.rx_irq_enable)
      | (sctrl.error_irq_enable & (flags.overrun_flag | flags.mode_fault_flag))))
      else $error("rx/err request wrong");
   // Fault behaviour
   fault_gate_a: assert property ($rose(flags.mode_fault_flag) |-> $past(sctrl.mode_fault_enable))
      else $error("fault set while disabled");
   master_fault_a: assert property ($rose(flags.mode_fault_flag) && ctrl.master_select
      |-> !ctrl.module_enable && flags.transmit_empty_flag && !pins.sck_oe && !pins.mosi_oe)
      else $error("master fault side effects missing");
   keep_role_a: assert property ($rose(flags.mode_fault_flag) && !$past(ctrl_wr)
      |-> $stable(ctrl.master_select)) else $error("role bit changed by fault");
   slave_fault_a: assert property ($rose(flags.mode_fault_flag) && !ctrl.master_select
      && !$past(ctrl_wr) |-> $stable(ctrl.module_enable)) else $error("slave fault touched enable");
   fault_clear_a: assert property ($fell(flags.mode_fault_flag) |-> $past(ctrl_wr))
      else $error("fault cleared without control write");
   // Pins, partial reset and protected break
   pin_dir_a: assert property (port_owned && ctrl.master_select ##1 port_owned
      && ctrl.master_select |-> pins.sck_oe && pins.mosi_oe && !pins.miso_oe)
      else $error("master pin directions wrong");
   miso_float_a: assert property (ss_n [*4] |-> !pins.miso_oe)
      else $error("deselected slave drives data out");
   disabled_a: assert property (!ctrl.module_enable ##1 !ctrl.module_enable
      |-> flags.transmit_empty_flag && !port_owned) else $error("disabled port not parked");
   break_keep_a: assert property (data_wr && break_active && !break_clear_enable
      && flags.transmit_empty_flag |=> flags.transmit_empty_flag) else $error("break write cleared");

   // Main scenarios reached
   cover property ($rose(flags.mode_fault_flag) && ctrl.master_select);
   cover property ($rose(flags.mode_fault_flag) && !ctrl.master_select);
   cover property ($rose(flags.receive_full_flag));
   cover property ($rose(tx_irq));
endmodule

bind spm_port spm_port_monitor i_spm_port_monitor (.mclk, .rst_n, .ctrl_wr, .data_wr,
   .break_active, .break_clear_enable, .ss_n, .ctrl, .sctrl, .flags, .tx_irq, .rx_err_irq,
   .port_owned, .pins);

// >>> test/test_spm_port.sv
/*
 * Self-checking bench for the SPI port control block.
 * Assumes the far-end model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ns
module test_spm_port;
   logic mclk, rst_n, ctrl_wr, sctrl_wr, status_rd, data_rd, data_wr;
   logic stop_mode, break_active, break_clear_enable, sclk, ss_n, mosi, miso;
   logic tx_irq, rx_err_irq, port_owned;
   logic [7:0] data_wdata, rx_data;
   spm_pkg::spm_ctrl_t ctrl_wdata, ctrl;
   spm_pkg::spm_sctrl_t sctrl_wdata, sctrl;
   spm_pkg::spm_flags_t flags;
   spm_pkg::spm_pins_t pins;
   int fails, checks;

   spm_port i_spm_port (.mclk, .rst_n, .ctrl_wr, .ctrl_wdata, .sctrl_wr, .sctrl_wdata,
      .status_rd, .data_rd, .data_wr, .data_wdata, .stop_mode, .break_active,
      .break_clear_enable, .serial_clock_pin(sclk), .ss_n, .mosi_i(mosi), .miso_i(miso),
      .ctrl, .sctrl, .flags, .rx_data, .tx_irq, .rx_err_irq, .port_owned, .pins);
   spm_far_end i_spm_far_end (.sclk, .ss_n, .mosi, .miso, .sck_o(pins.sck_o),
      .mosi_o(pins.mosi_o));

   // Bus clock, 10 ns
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task print_verdict;
      if (fails == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask

   // One-cycle strobe: 0 ctrl, 1 sctrl, 2 data write, 3 status read, 4 data read
   task op(input int k, input logic [7:0] v);
      @(posedge mclk);
      ctrl_wdata <= spm_pkg::spm_ctrl_t'(v[5:0]);
      sctrl_wdata <= spm_pkg::spm_sctrl_t'(v[3:0]);
      data_wdata <= v;
      ctrl_wr <= (k == 0);
      sctrl_wr <= (k == 1);
      data_wr <= (k == 2);
      status_rd <= (k == 3);
      data_rd <= (k == 4);
      @(posedge mclk);
      {ctrl_wr, sctrl_wr, data_wr, status_rd, data_rd} <= 5'h00;
      @(posedge mclk);
      @(negedge mclk);
   endtask

   // Bounded wait for a received byte, then let rx_data settle
   task wait_rx(input int n);
      int i;
      i = 0;
      while (flags.receive_full_flag !== 1'b1 && i < n)
      begin
         @(posedge mclk);
         i++;
      end
      repeat (2) @(negedge mclk);
      chk({7'h00, flags.receive_full_flag}, 8'h01);
   endtask

   // Main sequence
   initial
   begin
      {ctrl_wr, sctrl_wr, data_wr, status_rd, data_rd, stop_mode, break_active} = 7'h00;
      {rst_n, break_clear_enable} = 2'h0;
      data_wdata = 8'h00;
      ctrl_wdata = spm_pkg::spm_ctrl_t'(6'h00);
      sctrl_wdata = spm_pkg::spm_sctrl_t'(4'h0);
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      chk({2'h0, ctrl}, 8'h14);
      chk({4'h0, flags}, 8'h01);
      // Master byte with the slowest rate so the echo settles
      op(1, 8'h03);
      chk({4'h0, sctrl}, 8'h03);
      op(0, 8'h37);
      chk({7'h00, tx_irq}, 8'h01);
      op(2, 8'ha5);
      wait_rx(2000);
      chk(rx_data, 8'h5a);
      chk({5'h00, pins.sck_oe, pins.mosi_oe, pins.miso_oe}, 8'h06);
      chk({7'h00, rx_err_irq}, 8'h01);
      op(3, 8'h00);
      op(4, 8'h00);
      chk({4'h0, flags}, 8'h01);
      // Stop holds a queued byte; the transfer runs once stop ends
      @(posedge mclk);
      stop_mode <= 1'b1;
      op(2, 8'h0f);
      repeat (4) @(negedge mclk);
      chk({4'h0, flags}, 8'h00);
      @(posedge mclk);
      stop_mode <= 1'b0;
      wait_rx(2000);
      chk(rx_data, 8'hf0);
      op(3, 8'h00);
      op(4, 8'h00);
      // Protected break: the write must leave everything alone
      @(posedge mclk);
      break_active <= 1'b1;
      op(2, 8'h11);
      chk({4'h0, flags}, 8'h01);
      @(posedge mclk);
      break_active <= 1'b0;
      // Fault detection disabled: select low is harmless
      op(1, 8'h07);
      op(0, 8'h16);
      i_spm_far_end.select_pulse();
      chk({4'h0, flags}, 8'h01);
      // Master fault and its side effects
      op(1, 8'h0f);
      i_spm_far_end.select_pulse();
      chk({2'h0, ctrl}, 8'h14);
      chk({4'h0, flags}, 8'h03);
      chk({7'h00, rx_err_irq}, 8'h01);
      chk({7'h00, port_owned}, 8'h00);
      op(0, 8'h14);
      chk({4'h0, flags}, 8'h03);
      op(3, 8'h00);
      op(0, 8'h02);
      chk({4'h0, flags}, 8'h01);
      chk({7'h00, rx_err_irq}, 8'h00);
      // Phase-zero slave: select alone faults, enable kept
      i_spm_far_end.select_pulse();
      chk({4'h0, flags}, 8'h03);
      chk({2'h0, ctrl}, 8'h02);
      op(3, 8'h00);
      op(0, 8'h26);
      chk({4'h0, flags}, 8'h01);
      // Phase-one slave: select alone is no fault, then a real byte
      i_spm_far_end.select_pulse();
      chk({4'h0, flags}, 8'h01);
      i_spm_far_end.frame(8'h3c);
      wait_rx(60);
      chk(rx_data, 8'h3c);
      chk({7'h00, rx_err_irq}, 8'h01);
      // Disable keeps control bits and the unread flag
      op(0, 8'h24);
      chk({2'h0, ctrl}, 8'h24);
      chk({4'h0, flags}, 8'h09);
      chk({7'h00, port_owned}, 8'h00);
      // Reset in mid-run restores everything
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      chk({4'h0, flags}, 8'h01);
      chk({2'h0, ctrl}, 8'h14);
      print_verdict;
   end

   // Watchdog: tests need about 2200 cycles, allow some nine times that
   initial
   begin
      #200000;
      fails++;
      print_verdict;
   end
endmodule
